// ---- shared/uart_flow_pkg.sv ----
// constants and helpers shared by the flow control block and its leaves
package uart_flow_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ofs_enhanced_feature = 8'h00;
  localparam logic [7:0] ofs_transmission_control = 8'h04;
  localparam logic [7:0] ofs_modem_control = 8'h08;
  localparam logic [7:0] ofs_interrupt_enable = 8'h0c;
  localparam logic [7:0] ofs_interrupt_ident = 8'h10;
  localparam logic [7:0] ofs_stop_char_first = 8'h14;
  localparam logic [7:0] ofs_stop_char_second = 8'h18;
  localparam logic [7:0] ofs_resume_char_first = 8'h1c;
  localparam logic [7:0] ofs_resume_char_second = 8'h20;
  localparam logic [7:0] ofs_line_word = 8'h24;
  localparam logic [7:0] ofs_flow_status = 8'h28;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int efr_auto_cts_bit = 7;
  localparam int efr_auto_rts_bit = 6;
  localparam int efr_special_bit = 5;
  localparam int efr_tx_first_bit = 3;
  localparam int efr_tx_second_bit = 2;
  localparam int efr_rx_first_bit = 1;
  localparam int efr_rx_second_bit = 0;
  localparam int mcr_rts_bit = 1;
  localparam int mcr_resume_any_bit = 5;
  localparam int ier_stop_int_bit = 5;
  localparam int iir_stop_bit = 4;
  localparam int iir_none_bit = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ctrl_rst = 8'h00;
  localparam logic [7:0] char_rst = 8'h00;
  localparam logic [1:0] word_len_rst = 2'h3;

  // threshold field counts in steps of four bytes
  function automatic logic [6:0] field_level(input logic [3:0] f);
    return {1'b0, f, 2'b00};
  endfunction

endpackage

// ---- hdl/char_matcher.sv ----
// recogniser for a single or paired flow character on the receive stream
module char_matcher (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic byte_valid,
  input wire logic [7:0] byte_in,
  input wire logic use_first,
  input wire logic use_second,
  input wire logic clear,
  input wire logic [7:0] ch_first,
  input wire logic [7:0] ch_second,
  output logic hit,
  output logic part
);
  logic seen_r;
  logic both;
  logic eq_first;
  logic eq_second;

  assign both = use_first && use_second;
  assign eq_first = byte_in == ch_first;
  assign eq_second = byte_in == ch_second;
  assign part = byte_valid && ((use_first && eq_first) || (use_second && eq_second));

  assign hit = byte_valid && (both ? (seen_r && eq_second) :
                              ((use_first && eq_first) || (use_second && eq_second)));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_r <= 1'b0;
    end else if (clear) begin
      seen_r <= 1'b0;
    end else if (byte_valid) begin
      seen_r <= both && eq_first;
    end
  end

  // a byte other than the first breaks a half-seen pair
  a_pair_order: assert property (@(posedge hclk) disable iff (!hresetn)
    (byte_valid && both && !eq_first && !clear) |=> !seen_r)
    else $error("pair start kept after another byte");

endmodule

// ---- hdl/rx_level_watch.sv ----
// receive level hysteresis between halt and resume thresholds
module rx_level_watch #(
  parameter int level_w = 7
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [level_w-1:0] level,
  input wire logic [3:0] halt_field,
  input wire logic [3:0] resume_field,
  output logic halted,
  output logic halt_edge,
  output logic resume_edge
);
  logic [level_w-1:0] halt_lvl;
  logic [level_w-1:0] resume_lvl;
  logic go_halt;
  logic go_resume;

  assign halt_lvl = level_w'(uart_flow_pkg::field_level(halt_field));
  assign resume_lvl = level_w'(uart_flow_pkg::field_level(resume_field));
  assign go_halt = !halted && (level >= halt_lvl);
  assign go_resume = halted && (level <= resume_lvl);

  // hold off until level falls back
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      halted <= 1'b0;
      halt_edge <= 1'b0;
      resume_edge <= 1'b0;
    end else begin
      halt_edge <= go_halt;
      resume_edge <= go_resume;
      if (go_halt) begin
        halted <= 1'b1;
      end else if (go_resume) begin
        halted <= 1'b0;
      end
    end
  end

  a_halt_entry: assert property (@(posedge hclk) disable iff (!hresetn)
    go_halt |=> (halted && halt_edge) ##1 !halt_edge)
    else $error("halt threshold not taken");

endmodule

// ---- hdl/uart_flow_control.sv ----
// flow control for one serial channel: cts/rts gating and stop/resume characters
//
// Behaviour
// - auto cts and auto rts enabled separately
// - data byte starts only while cts active when auto cts is on
// - cts changes raise no event when automatic
// - rts active below halt level, dropped at it
// - rts returns at resume level
// - every late byte after rts drop accepted
// - transmit stop/resume characters by two bits
// - receive comparison selected by two bits
// - any character resumes when enabled
// - second resume character then stored as data
// - special character flags, still stored, no halt
// - ident register read clears stop flag
// - stop finishes current byte then pauses
// - stop sets ident bit four when enabled
// - resume clears flag and restarts sending
// - stop characters sent at halt level
// - resume characters sent at resume level
// - flow characters cut to word length
module uart_flow_control #(
  parameter int level_w = 7
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic cts_n,
  output logic rts_n,
  input wire logic [level_w-1:0] rx_level,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_store,
  output logic [7:0] rx_store_data,
  input wire logic tx_fifo_valid,
  input wire logic [7:0] tx_fifo_data,
  output logic tx_fifo_pop,
  input wire logic tx_ready,
  output logic tx_start,
  output logic [7:0] tx_data,
  output logic irq,
  output logic cts_change
);
  typedef enum logic [1:0] {tx_idle, tx_launch, tx_run} tx_state_t;

  logic [7:0] efr_r, tcr_r, mcr_r, ier_r;
  logic [7:0] stop1_r, stop2_r, res1_r, res2_r;
  logic [1:0] wlen_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic bus_take, iir_read;
  logic [7:0] rd_nxt;
  logic cts_meta_r, cts_sync_r, cts_prev_r;
  logic stop_hit, stop_part, res_hit, res_part, special_hit;
  logic rx_sw, tx_sw, any_resume, consume;
  logic paused_r, any_resumed_r, stop_int_r;
  logic rx_halted, halt_edge, resume_edge;
  logic stop_req_r, resume_req_r, pair_pend_r;
  logic [7:0] pair_char_r;
  tx_state_t state_r;
  logic launch_ok, send_stop, send_resume, send_data, pair_go;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // keeps the low word-length bits, the framer does the rest
  function automatic logic [7:0] word_mask(input logic [7:0] d, input logic [1:0] wl);
    case (wl)
      2'h0: return d & 8'h1f;
      2'h1: return d & 8'h3f;
      2'h2: return d & 8'h7f;
      default: return d;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign bus_take = hsel && htrans[1] && hready;
  assign iir_read = bus_take && !hwrite && (haddr == uart_flow_pkg::ofs_interrupt_ident);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= bus_take && hwrite;
      if (bus_take) begin
        wr_addr_r <= haddr;
      end
    end
  end

  // both enables live in one control byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      efr_r <= uart_flow_pkg::ctrl_rst;
      tcr_r <= uart_flow_pkg::ctrl_rst;
      mcr_r <= uart_flow_pkg::ctrl_rst;
      ier_r <= uart_flow_pkg::ctrl_rst;
      stop1_r <= uart_flow_pkg::char_rst;
      stop2_r <= uart_flow_pkg::char_rst;
      res1_r <= uart_flow_pkg::char_rst;
      res2_r <= uart_flow_pkg::char_rst;
      wlen_r <= uart_flow_pkg::word_len_rst;
    end else if (wr_pend_r) begin
      case (wr_addr_r)
        uart_flow_pkg::ofs_enhanced_feature: efr_r <= hwdata[7:0];
        uart_flow_pkg::ofs_transmission_control: tcr_r <= hwdata[7:0];
        uart_flow_pkg::ofs_modem_control: mcr_r <= hwdata[7:0];
        uart_flow_pkg::ofs_interrupt_enable: ier_r <= hwdata[7:0];
        uart_flow_pkg::ofs_stop_char_first: stop1_r <= hwdata[7:0];
        uart_flow_pkg::ofs_stop_char_second: stop2_r <= hwdata[7:0];
        uart_flow_pkg::ofs_resume_char_first: res1_r <= hwdata[7:0];
        uart_flow_pkg::ofs_resume_char_second: res2_r <= hwdata[7:0];
        uart_flow_pkg::ofs_line_word: wlen_r <= hwdata[1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    case (haddr)
      uart_flow_pkg::ofs_enhanced_feature: rd_nxt = efr_r;
      uart_flow_pkg::ofs_transmission_control: rd_nxt = tcr_r;
      uart_flow_pkg::ofs_modem_control: rd_nxt = mcr_r;
      uart_flow_pkg::ofs_interrupt_enable: rd_nxt = ier_r;
      uart_flow_pkg::ofs_interrupt_ident: rd_nxt = {3'h0, stop_int_r, 3'h0, !stop_int_r};
      uart_flow_pkg::ofs_stop_char_first: rd_nxt = stop1_r;
      uart_flow_pkg::ofs_stop_char_second: rd_nxt = stop2_r;
      uart_flow_pkg::ofs_resume_char_first: rd_nxt = res1_r;
      uart_flow_pkg::ofs_resume_char_second: rd_nxt = res2_r;
      uart_flow_pkg::ofs_line_word: rd_nxt = {6'h00, wlen_r};
      uart_flow_pkg::ofs_flow_status: rd_nxt = {4'h0, rx_halted, paused_r, !rts_n, !cts_sync_r};
      default: rd_nxt = 8'h00;
    endcase
  end

  // read data is captured in the address phase so no wait state is needed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_take && !hwrite) begin
      hrdata <= {24'h00_0000, rd_nxt};
    end
  end

  // ----------------------------------------------------------------
  // modem lines
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cts_meta_r <= 1'b1;
      cts_sync_r <= 1'b1;
      cts_prev_r <= 1'b1;
    end else begin
      cts_meta_r <= cts_n;
      cts_sync_r <= cts_meta_r;
      cts_prev_r <= cts_sync_r;
    end
  end

  // no change event while auto cts runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cts_change <= 1'b0;
    end else begin
      cts_change <= (cts_sync_r ^ cts_prev_r) && !efr_r[uart_flow_pkg::efr_auto_cts_bit];
    end
  end

  rx_level_watch #(
    .level_w(level_w)
  ) level_watch (
    .hclk(hclk),
    .hresetn(hresetn),
    .level(rx_level),
    .halt_field(tcr_r[3:0]),
    .resume_field(tcr_r[7:4]),
    .halted(rx_halted),
    .halt_edge(halt_edge),
    .resume_edge(resume_edge)
  );

  // auto rts follows the level watch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rts_n <= 1'b1;
    end else if (efr_r[uart_flow_pkg::efr_auto_rts_bit]) begin
      rts_n <= rx_halted;
    end else begin
      rts_n <= !mcr_r[uart_flow_pkg::mcr_rts_bit];
    end
  end

  // ----------------------------------------------------------------
  // receive side character recognition
  // ----------------------------------------------------------------
  assign rx_sw = efr_r[uart_flow_pkg::efr_rx_first_bit] || efr_r[uart_flow_pkg::efr_rx_second_bit];
  assign tx_sw = efr_r[uart_flow_pkg::efr_tx_first_bit] || efr_r[uart_flow_pkg::efr_tx_second_bit];

  char_matcher stop_match (
    .hclk(hclk),
    .hresetn(hresetn),
    .byte_valid(rx_valid),
    .byte_in(rx_data),
    .use_first(efr_r[uart_flow_pkg::efr_rx_first_bit]),
    .use_second(efr_r[uart_flow_pkg::efr_rx_second_bit]),
    .clear(1'b0),
    .ch_first(stop1_r),
    .ch_second(stop2_r),
    .hit(stop_hit),
    .part(stop_part)
  );

  char_matcher resume_match (
    .hclk(hclk),
    .hresetn(hresetn),
    .byte_valid(rx_valid),
    .byte_in(rx_data),
    .use_first(efr_r[uart_flow_pkg::efr_rx_first_bit]),
    .use_second(efr_r[uart_flow_pkg::efr_rx_second_bit]),
    .clear(any_resume),
    .ch_first(res1_r),
    .ch_second(res2_r),
    .hit(res_hit),
    .part(res_part)
  );

  // special character compares against second stop
  assign special_hit = rx_valid && efr_r[uart_flow_pkg::efr_special_bit] && (rx_data == stop2_r);
  // any byte resumes after a stop unless it completes another stop
  assign any_resume = rx_valid && mcr_r[uart_flow_pkg::mcr_resume_any_bit] && paused_r && !stop_hit;
  // second resume after an any-resume is data
  assign consume = rx_sw && (stop_part || res_part) && !special_hit &&
                   !(any_resumed_r && (rx_data == res2_r));

  // bytes keep flowing into the fifo after rts drops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_store <= 1'b0;
      rx_store_data <= 8'h00;
      any_resumed_r <= 1'b0;
    end else begin
      rx_store <= rx_valid && !consume;
      if (rx_valid) begin
        rx_store_data <= rx_data;
        any_resumed_r <= any_resume;
      end
    end
  end

  // pause only gates the next start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      paused_r <= 1'b0;
    end else if (stop_hit) begin
      paused_r <= 1'b1;
    end else if (res_hit || any_resume) begin
      paused_r <= 1'b0;
    end
  end

  // set wins over a same-cycle clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_int_r <= 1'b0;
    end else if ((stop_hit || special_hit) && ier_r[uart_flow_pkg::ier_stop_int_bit]) begin
      stop_int_r <= 1'b1;
    end else if (res_hit || any_resume || iir_read) begin
      stop_int_r <= 1'b0;
    end
  end

  assign irq = stop_int_r;

  // ----------------------------------------------------------------
  // transmit scheduling
  // ----------------------------------------------------------------
  // requests from level crossings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_req_r <= 1'b0;
      resume_req_r <= 1'b0;
    end else begin
      if (halt_edge && tx_sw) begin
        stop_req_r <= 1'b1;
      end else if (resume_edge || send_stop) begin
        stop_req_r <= 1'b0;
      end
      if (resume_edge && tx_sw) begin
        resume_req_r <= 1'b1;
      end else if (halt_edge || send_resume) begin
        resume_req_r <= 1'b0;
      end
    end
  end

  assign launch_ok = (state_r == tx_idle) && tx_ready;
  assign send_stop = launch_ok && stop_req_r;
  assign send_resume = launch_ok && !stop_req_r && resume_req_r;
  // cts sampled at each data byte start, flow characters go regardless
  assign send_data = launch_ok && !stop_req_r && !resume_req_r && tx_fifo_valid && !paused_r &&
                     (!efr_r[uart_flow_pkg::efr_auto_cts_bit] || !cts_sync_r);
  assign pair_go = (state_r == tx_run) && tx_ready && pair_pend_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= tx_idle;
    end else begin
      case (state_r)
        tx_idle: if (send_stop || send_resume || send_data) state_r <= tx_launch;
        tx_launch: if (!tx_ready) state_r <= tx_run;
        tx_run: if (tx_ready) state_r <= pair_pend_r ? tx_launch : tx_idle;
        default: state_r <= tx_idle;
      endcase
    end
  end

  // both bits send first then second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pair_pend_r <= 1'b0;
      pair_char_r <= 8'h00;
    end else if (send_stop || send_resume) begin
      pair_pend_r <= efr_r[uart_flow_pkg::efr_tx_first_bit] && efr_r[uart_flow_pkg::efr_tx_second_bit];
      pair_char_r <= send_stop ? stop2_r : res2_r;
    end else if (pair_go) begin
      pair_pend_r <= 1'b0;
    end
  end

  // every character masked to word length
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_start <= 1'b0;
      tx_fifo_pop <= 1'b0;
      tx_data <= 8'h00;
    end else begin
      tx_start <= send_stop || send_resume || send_data || pair_go;
      tx_fifo_pop <= send_data;
      if (send_stop) begin
        tx_data <= word_mask(efr_r[uart_flow_pkg::efr_tx_first_bit] ? stop1_r : stop2_r, wlen_r);
      end else if (send_resume) begin
        tx_data <= word_mask(efr_r[uart_flow_pkg::efr_tx_first_bit] ? res1_r : res2_r, wlen_r);
      end else if (send_data) begin
        tx_data <= word_mask(tx_fifo_data, wlen_r);
      end else if (pair_go) begin
        tx_data <= word_mask(pair_char_r, wlen_r);
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_special_byte;
    special_hit && ier_r[uart_flow_pkg::ier_stop_int_bit];
  endsequence

  sequence s_flag_and_store;
    stop_int_r && rx_store;
  endsequence

  a_cts_gate: assert property (
    tx_fifo_pop && $past(efr_r[uart_flow_pkg::efr_auto_cts_bit]) |-> !$past(cts_sync_r))
    else $error("byte started while cts inactive");

  a_rts_follow: assert property (
    efr_r[uart_flow_pkg::efr_auto_rts_bit] && rx_halted |=> rts_n)
    else $error("rts active at halt level");

  a_cts_quiet: assert property (
    $past(efr_r[uart_flow_pkg::efr_auto_cts_bit]) |-> !cts_change)
    else $error("cts event under automatic gating");

  a_stop_pause: assert property (
    stop_hit |=> paused_r ##1 (!tx_fifo_pop || !$past(paused_r)))
    else $error("stop character did not pause");

  a_special_keep: assert property (
    s_special_byte ##0 !paused_r |=> s_flag_and_store ##0 !paused_r)
    else $error("special character mishandled");

  a_iir_clear: assert property (
    iir_read && !stop_hit && !special_hit |=> !stop_int_r)
    else $error("ident read left stop flag");

  a_pair_send: assert property (
    send_stop && efr_r[uart_flow_pkg::efr_tx_first_bit] && efr_r[uart_flow_pkg::efr_tx_second_bit]
    |=> tx_start && tx_data == word_mask(stop1_r, wlen_r) && pair_pend_r)
    else $error("stop pair not queued");

endmodule

// ---- test/far_line.sv ----
// far side line model: a started byte keeps the transmitter busy, then idle
module far_line (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tx_start,
  input wire logic [7:0] slow,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] busy;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 8'h00;
    end else if (tx_start) begin
      busy <= slow + 8'h02;
    end else if (busy != 8'h00) begin
      busy <= busy - 8'h01;
    end
  end
  assign tx_ready = (busy == 8'h00);
endmodule

// ---- test/tb_top.sv ----
// self-checking bench for the uart flow control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] enhanced_feature_reg = uart_flow_pkg::ofs_enhanced_feature;
  localparam logic [7:0] lwd = uart_flow_pkg::ofs_line_word;
  localparam logic [7:0] iid = uart_flow_pkg::ofs_interrupt_ident;
  localparam logic [7:0] s1 = 8'h93, s2 = 8'h94, r1 = 8'h95, r2 = 8'h96;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, cts_n = 1'h0, rx_valid = 1'h0;
  logic tx_fifo_valid = 1'h0, hreadyout, hresp, rts_n, rx_store, tx_fifo_pop, tx_ready, tx_start, irq, cts_change;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] h;
  logic [6:0] rx_level = 7'h00;
  logic [7:0] haddr = 8'h00, rx_data = 8'h00, tx_fifo_data = 8'h00, slow = 8'h00, tx_data, rx_store_data;
  logic [31:0] hwdata = 32'h0, hrdata, q, seed = 32'hece21deb, tseed = 32'hece21deb;
  logic [7:0] sent[$], popped[$], ex[$];
  int errors = 0, checks = 0, ncc = 0, n0, m;

  always #4 hclk = ~hclk;

  uart_flow_control #(.level_w(7)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .cts_n, .rts_n, .rx_level, .rx_valid, .rx_data,
    .rx_store, .rx_store_data, .tx_fifo_valid, .tx_fifo_data, .tx_fifo_pop, .tx_ready, .tx_start,
    .tx_data, .irq, .cts_change);
  far_line far (.hclk, .hresetn, .tx_start, .slow, .tx_ready);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] cut(input logic [7:0] c, input int wl);
    return c & (8'hff >> (3 - wl));
  endfunction

  always @(negedge hclk) begin
    if (tx_start === 1'h1) sent.push_back(tx_data);
    if (cts_change === 1'h1) ncc++;
    if (tx_fifo_pop === 1'h1) begin
      popped.push_back(tx_fifo_data);
      tseed = lfsr(tseed);
    end
  end
  always @(posedge hclk) tx_fifo_data <= {1'h0, tseed[6:0]};

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    if (errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic hold();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 40);
    if (hreadyout !== 1'h1) begin
      errors++;
      end_of_test();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    hold();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    hold();
    q = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask
  task automatic rx(input logic [7:0] b, input logic st);
    @(posedge hclk);
    rx_valid <= 1'h1;
    rx_data <= b;
    @(posedge hclk);
    rx_valid <= 1'h0;
    @(negedge hclk);
    chk("rx_store", 32'(st), 32'(rx_store));
    if (st) chk("rx_store_data", 32'(b), 32'(rx_store_data));
  endtask
  task automatic lvl(input logic [6:0] v);
    @(posedge hclk);
    rx_level <= v;
    repeat (5) @(negedge hclk);
  endtask
  task automatic wsent(input int n);
    int k;
    @(posedge hclk);
    for (k = 0; k < 400 && sent.size() < n; k++) @(posedge hclk);
    if (sent.size() < n) begin
      errors++;
      end_of_test();
    end
  endtask

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    chk("rts_n reset", 32'h1, 32'(rts_n));
    bus(1'h0, iid, 32'h0);
    chk("ident reset", 32'h1, q);
    bus(1'h0, 8'h3c, 32'h0);
    chk("unmapped", 32'h0, q);
    n0 = ncc;
    cts_n <= 1'h1;
    cyc(8);
    chk("cts_change", 32'(n0 + 1), 32'(ncc));
    bus(1'h1, enhanced_feature_reg, 32'h80);
    n0 = ncc;
    tx_fifo_valid <= 1'h1;
    slow <= 8'h28;
    cyc(20);
    chk("tx held", 32'h0, sent.size());
    cts_n <= 1'h0;
    wsent(1);
    // remote blocks the next byte early
    cts_n <= 1'h1;
    cyc(80);
    chk("tx gated", 32'h1, sent.size());
    chk("tx byte", 32'(popped[0]), 32'(sent[0]));
    chk("cts_change auto", 32'(n0), 32'(ncc));
    cts_n <= 1'h0;
    wsent(2);
    tx_fifo_valid <= 1'h0;
    slow <= 8'h00;
    cyc(60);
    bus(1'h1, enhanced_feature_reg, 32'h40);
    for (m = 0; m < 3; m++) begin
      seed = lfsr(seed);
      h = seed[3:0] | 4'h1;
      bus(1'h1, uart_flow_pkg::ofs_transmission_control, 32'({h - 4'h1, h}));
      lvl(7'h00);
      lvl(7'({h, 2'h0}) - 7'h1);
      chk("rts below halt", 32'h0, 32'(rts_n));
      lvl(7'({h, 2'h0}));
      chk("rts at halt", 32'h1, 32'(rts_n));
      rx({1'h0, seed[14:8]}, 1'h1);
      lvl(7'({h - 4'h1, 2'h0}) + 7'h1);
      chk("rts held off", 32'h1, 32'(rts_n));
      lvl(7'({h - 4'h1, 2'h0}));
      chk("rts resumed", 32'h0, 32'(rts_n));
    end
    // level back to empty so the new thresholds start from no halt
    lvl(7'h00);
    for (m = 0; m < 4; m++) begin
      bus(1'h1, uart_flow_pkg::ofs_stop_char_first + 8'(m * 4), 32'(s1) + 32'(m));
    end
    bus(1'h1, uart_flow_pkg::ofs_transmission_control, 32'h23);
    for (m = 1; m < 4; m++) begin
      bus(1'h1, lwd, 32'(m - 1));
      bus(1'h1, enhanced_feature_reg, 32'(m << 2));
      sent.delete();
      slow <= 8'(m * 10);
      ex = {};
      if (m[1]) ex.push_back(cut(s1, m - 1));
      if (m[0]) ex.push_back(cut(s2, m - 1));
      if (m[1]) ex.push_back(cut(r1, m - 1));
      if (m[0]) ex.push_back(cut(r2, m - 1));
      lvl(7'h0c);
      wsent(ex.size() / 2);
      lvl(7'h08);
      wsent(ex.size());
      cyc(40);
      chk("flow count", 32'(ex.size()), 32'(sent.size()));
      for (n0 = 0; n0 < ex.size(); n0++) chk("flow char", 32'(ex[n0]), 32'(sent[n0]));
    end
    bus(1'h1, uart_flow_pkg::ofs_interrupt_enable, 32'h20);
    bus(1'h1, lwd, 32'h3);
    for (m = 1; m < 4; m++) begin
      bus(1'h1, enhanced_feature_reg, 32'(m));
      if (m[1]) rx(s1, 1'h0);
      if (m[0]) rx(s2, 1'h0);
      chk("irq stop", 32'h1, 32'(irq));
      @(posedge hclk);
      tx_fifo_valid <= 1'h1;
      sent.delete();
      cyc(30);
      chk("paused", 32'h0, sent.size());
      // status: not halted, paused, rts inactive, cts active
      bus(1'h0, uart_flow_pkg::ofs_flow_status, 32'h0);
      chk("status paused", 32'h5, q);
      if (m[1]) rx(r1, 1'h0);
      if (m[0]) rx(r2, 1'h0);
      chk("irq resume", 32'h0, 32'(irq));
      wsent(1);
      tx_fifo_valid <= 1'h0;
      cyc(60);
    end
    bus(1'h1, enhanced_feature_reg, 32'h20);
    rx(s2, 1'h1);
    chk("irq special", 32'h1, 32'(irq));
    bus(1'h0, iid, 32'h0);
    chk("ident stop", 32'h10, q);
    bus(1'h0, iid, 32'h0);
    chk("ident clear", 32'h1, q);
    chk("irq clear", 32'h0, 32'(irq));
    bus(1'h1, enhanced_feature_reg, 32'h3);
    bus(1'h1, uart_flow_pkg::ofs_modem_control, 32'h20);
    rx(s1, 1'h0);
    rx(s2, 1'h0);
    chk("irq pair", 32'h1, 32'(irq));
    rx(r1, 1'h0);
    chk("irq any", 32'h0, 32'(irq));
    rx(r2, 1'h1);
    rx(s1, 1'h0);
    rx(s2, 1'h0);
    rx(8'h41, 1'h1);
    chk("irq any byte", 32'h0, 32'(irq));
    end_of_test();
  end
endmodule
